// ===== hw/wrf_regfile.sv
`timescale 1ns/1ps
`default_nettype none
`include "wrf_consts.svh"
module wrf_regfile
  import wrf_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic clk_en,
  // instruction issue
  input wire logic op_valid,
  input wire wrf_op_e op,
  input wire logic byte_mode,
  input wire logic [3:0] dst_idx,
  input wire logic [15:0] file_data,
  input wire logic [15:0] result_a,
  input wire logic [15:0] result_b,
  // 17x17 multiply operands
  input wire logic [3:0] mul_src_a,
  input wire logic [3:0] mul_src_b,
  input wire logic mul_a_signed,
  input wire logic mul_b_signed,
  // dsp prefetch class
  input wire logic dsp_prefetch,
  input wire logic [1:0] dsp_opnd_a,
  input wire logic [1:0] dsp_opnd_b,
  input wire logic [1:0] multiply_sign_mode_field,
  input wire logic dsp_wb_valid,
  input wire logic [15:0] dsp_wb_data,
  input wire logic [3:0] acc_src_a,
  input wire logic [3:0] acc_src_b,
  // general read ports
  input wire logic [3:0] rd_idx,
  output logic [15:0] rd_data,
  output logic [15:0] default_working_register,
  output logic [15:0] frame_pointer_register,
  output logic [15:0] stack_pointer_register,
  output logic [15:0] dsp_opnd_a_data,
  output logic [15:0] dsp_opnd_b_data,
  output logic dsp_opnd_a_signed,
  output logic dsp_opnd_b_signed,
  output logic [15:0] prefetch_x_ptr0,
  output logic [15:0] prefetch_x_ptr1,
  output logic [15:0] prefetch_y_ptr0,
  output logic [15:0] prefetch_y_ptr1,
  output logic [15:0] prefetch_offset_register,
  output logic [15:0] file_wr_data
);
  // ***********************************************
  // register array and helpers
  // ***********************************************
  logic [15:0] regs [16];
  logic [31:0] mul_product;
  logic [31:0] fmul_product;
  logic [15:0] mul_a;
  logic [15:0] mul_b;
  logic [3:0] pair_lo;

  function automatic logic [15:0] merge_byte(input logic [15:0] old_v,
                                             input logic [15:0] new_v,
                                             input logic bm);
    merge_byte = bm ? {old_v[15:8], new_v[7:0]} : new_v;
  endfunction

  function automatic logic [3:0] dsp_reg(input logic [3:0] base, input logic [1:0] sel);
    dsp_reg = base + {2'h0, sel};
  endfunction

  // any register feeds the general multiplier, including 14 and 15
  assign mul_a = regs[mul_src_a];
  assign mul_b = regs[mul_src_b];
  assign pair_lo = {dst_idx[3:1], 1'h0};

  wrf_mul17 u_mul (
    .a(mul_a),
    .b(mul_b),
    .a_signed(mul_a_signed),
    .b_signed(mul_b_signed),
    .product(mul_product)
  );

  // unsigned file value by default register; byte mode uses low bytes
  always_comb begin
    if (byte_mode) begin
      fmul_product = {16'h0000, 8'h00, file_data[7:0]} * {24'h000000, regs[0][7:0]};
    end else begin
      fmul_product = {16'h0000, file_data} * {16'h0000, regs[0]};
    end
  end

  // ***********************************************
  // register writes
  // ***********************************************
  always_ff @(posedge mclk) begin
    if (reset) begin
      for (int i = 0; i < 16; i++) begin
        regs[i] <= `WRF_RESET_VAL;
      end
    end else if (clk_en) begin
      if (op_valid) begin
        case (op)
          WRF_OP_FWR: begin
            // file op result into default register; byte moves only here
            regs[`WRF_IDX_DEFAULT] <= merge_byte(regs[0], result_a, byte_mode);
          end
          WRF_OP_DIV: begin
            regs[`WRF_IDX_QUOT] <= result_a;
            regs[`WRF_IDX_REM] <= result_b;
          end
          WRF_OP_FMUL: begin
            if (byte_mode) begin
              regs[`WRF_IDX_PROD_LO] <= fmul_product[15:0];
            end else begin
              regs[`WRF_IDX_PROD_LO] <= fmul_product[15:0];
              regs[`WRF_IDX_PROD_HI] <= fmul_product[31:16];
            end
          end
          WRF_OP_MUL17: begin
            regs[pair_lo] <= mul_product[15:0];
            regs[pair_lo + 4'h1] <= mul_product[31:16];
          end
          WRF_OP_FRAME: begin
            regs[`WRF_IDX_FRAME] <= result_a;
            regs[`WRF_IDX_STACK] <= result_b;
          end
          WRF_OP_STACK: begin
            regs[`WRF_IDX_STACK] <= result_a;
          end
          WRF_OP_WMOV: begin
            // word moves to any register, frame and stack pointer included
            regs[dst_idx] <= file_data;
          end
          default: begin
          end
        endcase
      end
      // dsp write-back lands after any same-cycle op write
      if (dsp_wb_valid && dsp_prefetch) begin
        regs[`WRF_IDX_WRBACK] <= dsp_wb_data;
      end
    end
  end

  // ***********************************************
  // registered read outputs
  // ***********************************************
  always_ff @(posedge mclk) begin
    if (reset) begin
      rd_data <= `WRF_RESET_VAL;
      default_working_register <= `WRF_RESET_VAL;
      frame_pointer_register <= `WRF_RESET_VAL;
      stack_pointer_register <= `WRF_RESET_VAL;
      prefetch_x_ptr0 <= `WRF_RESET_VAL;
      prefetch_x_ptr1 <= `WRF_RESET_VAL;
      prefetch_y_ptr0 <= `WRF_RESET_VAL;
      prefetch_y_ptr1 <= `WRF_RESET_VAL;
      prefetch_offset_register <= `WRF_RESET_VAL;
      file_wr_data <= `WRF_RESET_VAL;
    end else if (clk_en) begin
      rd_data <= regs[rd_idx];
      default_working_register <= regs[`WRF_IDX_DEFAULT];
      frame_pointer_register <= regs[`WRF_IDX_FRAME];
      stack_pointer_register <= regs[`WRF_IDX_STACK];
      prefetch_x_ptr0 <= regs[`WRF_IDX_XPTR_BASE];
      prefetch_x_ptr1 <= regs[`WRF_IDX_XPTR_BASE + 4'h1];
      prefetch_y_ptr0 <= regs[`WRF_IDX_YPTR_BASE];
      prefetch_y_ptr1 <= regs[`WRF_IDX_YPTR_BASE + 4'h1];
      prefetch_offset_register <= regs[`WRF_IDX_OFFSET];
      // byte stores take only the low byte of the default register
      file_wr_data <= byte_mode ? {8'h00, regs[0][7:0]} : regs[0];
    end
  end

  // ***********************************************
  // dsp operand fetch
  // ***********************************************
  always_ff @(posedge mclk) begin
    if (reset) begin
      dsp_opnd_a_data <= `WRF_RESET_VAL;
      dsp_opnd_b_data <= `WRF_RESET_VAL;
      dsp_opnd_a_signed <= `WRF_SIGNED_RESET;
      dsp_opnd_b_signed <= `WRF_SIGNED_RESET;
    end else if (clk_en) begin
      if (dsp_prefetch) begin
        // two-bit select cannot leave registers four to seven, so no range check
        dsp_opnd_a_data <= regs[dsp_reg(`WRF_IDX_OPND_BASE, dsp_opnd_a)];
        dsp_opnd_b_data <= regs[dsp_reg(`WRF_IDX_OPND_BASE, dsp_opnd_b)];
        if (multiply_sign_mode_field == `WRF_SIGN_MIXED) begin
          dsp_opnd_a_signed <= dsp_opnd_a[0];
          dsp_opnd_b_signed <= dsp_opnd_b[0];
        end else begin
          dsp_opnd_a_signed <= ~multiply_sign_mode_field[0];
          dsp_opnd_b_signed <= ~multiply_sign_mode_field[0];
        end
      end else begin
        dsp_opnd_a_data <= regs[acc_src_a];
        dsp_opnd_b_data <= regs[acc_src_b];
        dsp_opnd_a_signed <= ~multiply_sign_mode_field[0];
        dsp_opnd_b_signed <= ~multiply_sign_mode_field[0];
      end
    end
  end

  // ***********************************************
  // checks
  // ***********************************************
  a_div_quot_rem: assert property (@(posedge mclk) disable iff (reset)
    clk_en && op_valid && op == WRF_OP_DIV && !(dsp_wb_valid && dsp_prefetch) ##1 clk_en
    |-> ##1 default_working_register == $past(result_a, 2))
    else $error("quotient not in register zero");
  a_fmul_word_hi: assert property (@(posedge mclk) disable iff (reset)
    clk_en && op_valid && op == WRF_OP_FMUL && !byte_mode
    |=> regs[3] == $past(fmul_product[31:16]) && regs[2] == $past(fmul_product[15:0]))
    else $error("word file multiply pair wrong");
  a_fmul_byte_keep: assert property (@(posedge mclk) disable iff (reset)
    clk_en && op_valid && op == WRF_OP_FMUL && byte_mode |=> $stable(regs[3]))
    else $error("byte file multiply touched register three");
  // checked on the registers, so a signed multiply path would show here
  a_fmul_unsigned: assert property (@(posedge mclk) disable iff (reset)
    clk_en && op_valid && op == WRF_OP_FMUL && !byte_mode
    |=> {regs[3], regs[2]} == $past(32'(file_data) * 32'(regs[0])))
    else $error("file multiply not unsigned");
  a_fwr_byte_hi: assert property (@(posedge mclk) disable iff (reset)
    clk_en && op_valid && op == WRF_OP_FWR && byte_mode |=> $stable(regs[0][15:8]))
    else $error("byte write changed upper byte");
  a_mixed_sign: assert property (@(posedge mclk) disable iff (reset)
    clk_en && dsp_prefetch && multiply_sign_mode_field == `WRF_SIGN_MIXED
    |=> dsp_opnd_a_signed == $past(dsp_opnd_a[0]) && dsp_opnd_b_signed == $past(dsp_opnd_b[0]))
    else $error("mixed sign mode wrong");
  a_wb_dest: assert property (@(posedge mclk) disable iff (reset)
    clk_en && dsp_wb_valid && dsp_prefetch |=> regs[13] == $past(dsp_wb_data))
    else $error("write-back missed register thirteen");
  a_stack_out: assert property (@(posedge mclk) disable iff (reset)
    clk_en && op_valid && op == WRF_OP_STACK ##1 clk_en
    |=> stack_pointer_register == $past(result_a, 2))
    else $error("stack pointer not updated");
  a_frame_ptr: assert property (@(posedge mclk) disable iff (reset)
    clk_en && op_valid && op == WRF_OP_FRAME |=> regs[14] == $past(result_a))
    else $error("frame pointer not updated");
  a_word_move: assert property (@(posedge mclk) disable iff (reset)
    clk_en && op_valid && op == WRF_OP_WMOV && !(dsp_wb_valid && dst_idx == 4'hD)
    |=> regs[$past(dst_idx)] == $past(file_data))
    else $error("word move lost");
endmodule // wrf_regfile
`default_nettype wire

// ===== hw/wrf_consts.svh
`ifndef WRF_CONSTS_SVH
`define WRF_CONSTS_SVH
// fixed register roles
`define WRF_IDX_DEFAULT 4'h0
`define WRF_IDX_QUOT 4'h0
`define WRF_IDX_REM 4'h1
`define WRF_IDX_PROD_LO 4'h2
`define WRF_IDX_PROD_HI 4'h3
`define WRF_IDX_OPND_BASE 4'h4
`define WRF_IDX_XPTR_BASE 4'h8
`define WRF_IDX_YPTR_BASE 4'hA
`define WRF_IDX_OFFSET 4'hC
`define WRF_IDX_WRBACK 4'hD
`define WRF_IDX_FRAME 4'hE
`define WRF_IDX_STACK 4'hF
// sign mode field value for mixed-sign operands
`define WRF_SIGN_MIXED 2'h2
`define WRF_RESET_VAL 16'h0000
// operand sign flags come out of reset as signed
`define WRF_SIGNED_RESET 1'h1
`endif

// ===== hw/wrf_pkg.sv
`default_nettype none
package wrf_pkg;
  typedef logic [15:0] wrf_word_t;
  typedef logic [3:0] wrf_idx_t;
  typedef enum logic [7:0] {
    WRF_OP_NONE = 8'h01,
    WRF_OP_FWR = 8'h02,
    WRF_OP_DIV = 8'h04,
    WRF_OP_FMUL = 8'h08,
    WRF_OP_MUL17 = 8'h10,
    WRF_OP_FRAME = 8'h20,
    WRF_OP_STACK = 8'h40,
    WRF_OP_WMOV = 8'h80
  } wrf_op_e;
endpackage
`default_nettype wire

// ===== hw/wrf_mul17.sv
`timescale 1ns/1ps
`default_nettype none
module wrf_mul17
  import wrf_pkg::*;
(
  input wire logic [15:0] a,
  input wire logic [15:0] b,
  input wire logic a_signed,
  input wire logic b_signed,
  output logic [31:0] product
);
  logic signed [16:0] a_ext;
  logic signed [16:0] b_ext;
  logic signed [33:0] full;
  // 17x17 core multiplier: sign bit chosen per operand
  always_comb begin
    a_ext = {a_signed & a[15], a};
    b_ext = {b_signed & b[15], b};
    full = a_ext * b_ext;
    product = full[31:0];
  end
endmodule // wrf_mul17
`default_nettype wire

// ===== tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import wrf_pkg::*;
;
  // ****************
  // stimulus and dut
  // ****************
  logic mclk, reset, clk_en, op_valid, byte_mode, mul_a_signed, mul_b_signed;
  logic dsp_prefetch, dsp_wb_valid, dsp_opnd_a_signed, dsp_opnd_b_signed;
  wrf_op_e op;
  logic [3:0] dst_idx, mul_src_a, mul_src_b, acc_src_a, acc_src_b, rd_idx;
  logic [1:0] dsp_opnd_a, dsp_opnd_b, multiply_sign_mode_field;
  logic [15:0] file_data, result_a, result_b, dsp_wb_data, rd_data, default_working_register;
  logic [15:0] frame_pointer_register, stack_pointer_register, dsp_opnd_a_data, dsp_opnd_b_data;
  logic [15:0] prefetch_x_ptr0, prefetch_x_ptr1, prefetch_y_ptr0, prefetch_y_ptr1;
  logic [15:0] prefetch_offset_register, file_wr_data, v;
  int err_total, checked;

  wrf_regfile i_wrf_regfile (.mclk, .reset, .clk_en, .op_valid, .op, .byte_mode, .dst_idx,
    .file_data, .result_a, .result_b, .mul_src_a, .mul_src_b, .mul_a_signed, .mul_b_signed,
    .dsp_prefetch, .dsp_opnd_a, .dsp_opnd_b, .multiply_sign_mode_field, .dsp_wb_valid,
    .dsp_wb_data, .acc_src_a, .acc_src_b, .rd_idx, .rd_data, .default_working_register,
    .frame_pointer_register, .stack_pointer_register, .dsp_opnd_a_data, .dsp_opnd_b_data,
    .dsp_opnd_a_signed, .dsp_opnd_b_signed, .prefetch_x_ptr0, .prefetch_x_ptr1,
    .prefetch_y_ptr0, .prefetch_y_ptr1, .prefetch_offset_register, .file_wr_data);

  initial begin
    mclk = 0;
    forever #2.5 mclk = ~mclk;
  end

  // ****************
  // shared tasks
  // ****************
  task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask

  // valid drops here, not in go, so back-to-back ops never glitch it low
  task automatic tick();
    op_valid = 0;
    op = WRF_OP_NONE;
    @(posedge mclk);
    #1;
  endtask

  // ops are one cycle each; valid stays up across back-to-back issue
  task automatic go(input wrf_op_e o, input logic [15:0] a, b, input logic bm,
                    input logic [3:0] d, input logic [15:0] f);
    op = o;
    result_a = a;
    result_b = b;
    byte_mode = bm;
    dst_idx = d;
    file_data = f;
    op_valid = 1;
    @(posedge mclk);
    #1;
  endtask

  task automatic rd(input logic [3:0] i);
    rd_idx = i;
    tick();
    v = rd_data;
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ****************
  // scenarios
  // ****************
  task automatic t_fwr();
    go(WRF_OP_FWR, 16'h1234, 16'h0, 0, 4'h0, 16'h0);
    tick();
    cmp("reg0", 16'h1234, default_working_register);
    cmp("fwd", 16'h1234, file_wr_data);
    go(WRF_OP_FWR, 16'hABCD, 16'h0, 1, 4'h0, 16'h0);
    tick();
    cmp("reg0b", 16'h12CD, default_working_register);
    cmp("fwdb", 16'h00CD, file_wr_data);
    clk_en = 0;
    go(WRF_OP_FWR, 16'h5555, 16'h0, 0, 4'h0, 16'h0);
    clk_en = 1;
    go(WRF_OP_NONE, 16'h5555, 16'h0, 0, 4'h0, 16'h0);
    tick();
    cmp("reg0hold", 16'h12CD, default_working_register);
  endtask

  task automatic t_div_fmul();
    go(WRF_OP_DIV, 16'h00F1, 16'h0007, 0, 4'h0, 16'h0);
    rd(4'h1);
    cmp("rem", 16'h0007, v);
    cmp("quot", 16'h00F1, default_working_register);
    go(WRF_OP_FWR, 16'h7705, 16'h0, 0, 4'h0, 16'h0);
    go(WRF_OP_WMOV, 16'h0, 16'h0, 0, 4'h2, 16'h1235);
    go(WRF_OP_WMOV, 16'h0, 16'h0, 0, 4'h3, 16'h1000);
    go(WRF_OP_FMUL, 16'h0, 16'h0, 1, 4'h0, 16'h1255);
    rd(4'h2);
    cmp("pb_lo", 16'h01A9, v);
    rd(4'h3);
    cmp("pb_hi", 16'h1000, v);
    go(WRF_OP_FMUL, 16'h0, 16'h0, 0, 4'h0, 16'h1255);
    rd(4'h2);
    cmp("pw_lo", 16'hDEA9, v);
    rd(4'h3);
    cmp("pw_hi", 16'h0885, v);
    cmp("reg0keep", 16'h7705, default_working_register);
  endtask

  task automatic t_all_regs();
    for (int i = 0; i < 16; i++)
      go(WRF_OP_WMOV, 16'h0, 16'h0, 0, 4'(i), {4'hA, 4'(i), ~4'(i), 4'(i)});
    for (int i = 0; i < 16; i++) begin
      rd(4'(i));
      cmp("wmov", {4'hA, 4'(i), ~4'(i), 4'(i)}, v);
    end
    cmp("fp", 16'hAE1E, frame_pointer_register);
    cmp("sp", 16'hAF0F, stack_pointer_register);
    cmp("x0", 16'hA878, prefetch_x_ptr0);
    cmp("x1", 16'hA969, prefetch_x_ptr1);
    cmp("y0", 16'hAA5A, prefetch_y_ptr0);
    cmp("y1", 16'hAB4B, prefetch_y_ptr1);
    cmp("ofs", 16'hAC3C, prefetch_offset_register);
    go(WRF_OP_FRAME, 16'h0F00, 16'h0F40, 0, 4'h0, 16'h0);
    tick();
    cmp("fpl", 16'h0F00, frame_pointer_register);
    cmp("spl", 16'h0F40, stack_pointer_register);
    go(WRF_OP_STACK, 16'h0F42, 16'h0, 0, 4'h0, 16'h0);
    tick();
    cmp("sps", 16'h0F42, stack_pointer_register);
  endtask

  task automatic t_mul_dsp();
    go(WRF_OP_WMOV, 16'h0, 16'h0, 0, 4'h4, 16'h0003);
    go(WRF_OP_WMOV, 16'h0, 16'h0, 0, 4'h5, 16'h8000);
    mul_src_a = 4'h4;
    mul_src_b = 4'h5;
    go(WRF_OP_MUL17, 16'h0, 16'h0, 0, 4'h7, 16'h0);
    rd(4'h6);
    cmp("m_lo", 16'h8000, v);
    rd(4'h7);
    cmp("m_hi", 16'h0001, v);
    mul_a_signed = 1;
    mul_b_signed = 1;
    go(WRF_OP_MUL17, 16'h0, 16'h0, 0, 4'h3, 16'h0);
    rd(4'h3);
    cmp("ms_hi", 16'hFFFE, v);
    dsp_prefetch = 1;
    dsp_opnd_a = 2'h2;
    dsp_opnd_b = 2'h1;
    repeat (2) tick();
    cmp("oa", 16'h8000, dsp_opnd_a_data);
    cmp("ob", 16'h8000, dsp_opnd_b_data);
    cmp("oas", 16'h0, {15'h0, dsp_opnd_a_signed});
    cmp("obs", 16'h1, {15'h0, dsp_opnd_b_signed});
    multiply_sign_mode_field = 2'h1;
    tick();
    cmp("oau", 16'h0, {15'h0, dsp_opnd_a_signed});
    cmp("obu", 16'h0, {15'h0, dsp_opnd_b_signed});
    multiply_sign_mode_field = 2'h2;
    dsp_wb_valid = 1;
    dsp_wb_data = 16'h5A5A;
    tick();
    dsp_prefetch = 0;
    dsp_wb_data = 16'h1111;
    rd(4'hD);
    cmp("wb", 16'h5A5A, v);
    dsp_wb_valid = 0;
    rd(4'hD);
    cmp("wbno", 16'h5A5A, v);
    acc_src_a = 4'hF;
    acc_src_b = 4'hE;
    repeat (2) tick();
    cmp("acc", 16'h0F42, dsp_opnd_a_data);
    cmp("accb", 16'h0F00, dsp_opnd_b_data);
  endtask

  initial begin
    {op_valid, byte_mode, mul_a_signed, mul_b_signed} = '0;
    {dsp_prefetch, dsp_wb_valid, dst_idx, mul_src_a, mul_src_b} = '0;
    {acc_src_a, acc_src_b, rd_idx, dsp_opnd_a, dsp_opnd_b} = '0;
    {file_data, result_a, result_b, dsp_wb_data} = '0;
    multiply_sign_mode_field = 2'h2;
    op = WRF_OP_NONE;
    err_total = 0;
    checked = 0;
    reset = 1;
    clk_en = 1;
    repeat (8) @(posedge mclk);
    #1;
    reset = 0;
    tick();
    cmp("rst", 16'h0000, default_working_register);
    t_fwr();
    t_div_fmul();
    t_all_regs();
    t_mul_dsp();
    stop_test();
  end

  // whole run is under a hundred cycles
  initial begin
    #20000;
    err_total++;
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
